// ===== transceiver_reset_powerdown_control_tb_top.sv
module transceiver_reset_powerdown_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import trp_pkg::*;
  // ----------------------------------------------
  // Clock, reset and wiring
  // ----------------------------------------------
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awa, ara;
  logic [31:0] wda, rda;
  logic [3:0] wst;
  logic [1:0] brs, rrs;
  logic awv, awr, wva, wre, bva, bre, arv, arr, rva, rre, rfb;
  logic [NUM_CH-1:0] txa, rxa;
  logic [NUM_PLL-1:0] cmr;
  int error_cnt = 0;
  int n_compared = 0;
  // 100 MHz
  always #5 aclk = ~aclk;
  trp_top uut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wda), .s_axi_wstrb(wst), .s_axi_wvalid(wva),
    .s_axi_wready(wre), .s_axi_bresp(brs), .s_axi_bvalid(bva),
    .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rda), .s_axi_rresp(rrs),
    .s_axi_rvalid(rva), .s_axi_rready(rre), .tx_active(txa),
    .rx_active(rxa), .clock_multiplier_running(cmr),
    .refclk_buf_on(rfb));
  trp_ctl_model ctl (
    .aclk(aclk), .awa(awa), .awv(awv), .awr(awr), .wda(wda),
    .wst(wst), .wva(wva), .wre(wre), .brs(brs), .bva(bva), .bre(bre),
    .ara(ara), .arv(arv), .arr(arr), .rda(rda), .rrs(rrs), .rva(rva),
    .rre(rre));
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic final_report();
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
    logic [1:0] r;
    ctl.wr(a, d, r);
    chk("bresp", {30'h0, er}, {30'h0, r});
  endtask
  // Status word read into st for field checks
  logic [31:0] st;
  task automatic rchk(input string nm, input logic [7:0] a,
                      input logic [31:0] e, input logic [1:0] er);
    logic [1:0] r;
    ctl.rd(a, st, r);
    chk(nm, e, st);
    chk("rresp", {30'h0, er}, {30'h0, r});
  endtask
  task automatic rst_st();
    logic [1:0] r;
    ctl.rd(OFF_STATUS, st, r);
  endtask
  // ----------------------------------------------
  // Scenarios
  // ----------------------------------------------
  task automatic t_reset();
    rchk("ch_reset", OFF_CH_RESET, 32'(RST_CH_RESET), RESP_OKAY);
    rchk("pwr", OFF_PWR, 32'(RST_PWR), RESP_OKAY);
    rchk("cdr_mode", OFF_CDR_MODE, 32'(RST_CDR_MODE), RESP_OKAY);
    rchk("unmapped", 8'h20, 32'h0, RESP_SLVERR);
    wreg(OFF_STATUS, 32'hFFFF_FFFF, RESP_SLVERR);
    rchk("status", OFF_STATUS, 32'h1 << ST_BUSY_BIT, RESP_OKAY);
    chk("outs", 32'h1, {21'h0, txa, rxa, cmr, rfb});
  endtask
  task automatic t_pll();
    wreg(OFF_PWR, 32'h0, RESP_OKAY);
    cyc(50);
    chk("pll_on", 32'h3, {30'h0, cmr});
    rst_st();
    chk("lock_early", 32'h0, {30'h0, st[ST_TXLOCK_LSB+:2]});
    cyc(60);
    rst_st();
    chk("lock", 32'h3, {30'h0, st[ST_TXLOCK_LSB+:2]});
    chk("tx_held", 32'h0, {28'h0, txa});
    wreg(OFF_CH_RESET, 32'h0000_0FF0, RESP_OKAY);
    cyc(3);
    chk("tx_on", 32'hF, {28'h0, txa});
    rchk("ch_state", OFF_CH_STATE, 32'hF, RESP_OKAY);
  endtask
  task automatic t_rx();
    for (int i = 0; i < 200; i++) begin
      rst_st();
      if (st[ST_BUSY_BIT] === 1'b0) break;
    end
    chk("busy_end", 32'h0, {31'h0, st[ST_BUSY_BIT]});
    cyc(2);
    wreg(OFF_CH_RESET, 32'h0000_00F0, RESP_OKAY);
    cyc(60);
    rst_st();
    chk("cdr_lock", 32'hF, {28'h0, st[ST_CDRLOCK_LSB+:4]});
    chk("data_lock", 32'hF, {28'h0, st[ST_DATALOCK_LSB+:4]});
    chk("rx_held", 32'h0, {28'h0, rxa});
    cyc(10);
    wreg(OFF_CH_RESET, 32'h0, RESP_OKAY);
    cyc(3);
    chk("rx_on", 32'hF, {28'h0, rxa});
  endtask
  task automatic t_mode();
    logic [7:0] md [4] = '{8'h0F, 8'hFF, 8'hF0, 8'h00};
    logic [3:0] ex [4] = '{4'h0, 4'hF, 4'hF, 4'hF};
    for (int i = 0; i < 4; i++) begin
      wreg(OFF_CDR_MODE, {24'h0, md[i]}, RESP_OKAY);
      cyc(4);
      rst_st();
      chk("mode", {28'h0, ex[i]}, {28'h0, st[ST_DATALOCK_LSB+:4]});
    end
  endtask
  task automatic t_pwr();
    wreg(OFF_CH_RESET, 32'h0000_0102, RESP_OKAY);
    cyc(3);
    chk("one_ch", 32'hED, {24'h0, rxa, txa});
    wreg(OFF_CH_RESET, 32'h0, RESP_OKAY);
    wreg(OFF_PWR, 32'h1, RESP_OKAY);
    cyc(3);
    chk("pll1_only", 32'h2A, {26'h0, cmr, txa});
    wreg(OFF_PWR, 32'h4, RESP_OKAY);
    cyc(3);
    chk("blk_down", 32'h1, {21'h0, txa, rxa, cmr, rfb});
    rchk("ch_kept", OFF_CH_RESET, 32'h0, RESP_OKAY);
    wreg(OFF_PWR, 32'h0, RESP_OKAY);
    cyc(110);
    chk("tx_back", 32'hF, {28'h0, txa});
  endtask
  // Watchdog: whole run is some five hundred cycles
  initial begin
    repeat (20000) @(posedge aclk);
    error_cnt++;
    final_report();
  end
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    cyc(3);
    t_reset();
    t_pll();
    t_rx();
    t_mode();
    t_pwr();
    final_report();
  end
endmodule
bind trp_top trp_top_checker chk_i (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .tx_active(tx_active), .rx_active(rx_active),
  .clock_multiplier_running(clock_multiplier_running),
  .refclk_buf_on(refclk_buf_on));

// ===== trp_cdr.sv
module trp_cdr (
  input wire logic aclk,
  input wire logic aresetn,
  trp_cdr_if.cdr bus
);
  import trp_pkg::*;

  logic [CNT_W-1:0] cnt_q;
  logic cdr_lock_q;
  logic data_lock_q;

  // Model of one CDR: counts to lock after analog reset releases
  // Held reset is combined asynchronously in the analog core; here
  // the digital image honours it on every cycle it is high.
  always_ff @(posedge aclk) begin
    if (!aresetn || bus.analog_rst || !bus.pll_ok) begin
      cnt_q <= '0;
      cdr_lock_q <= 1'b0;
      data_lock_q <= 1'b0;
    end else begin
      if (cnt_q != CNT_W'(CDR_LOCK_CYC)) begin
        cnt_q <= cnt_q + CNT_W'(1);
      end
      cdr_lock_q <= (cnt_q == CNT_W'(CDR_LOCK_CYC));
      // Manual reference tracking forces data lock low unless data tracking is also set
      if (bus.to_data) begin
        data_lock_q <= cdr_lock_q;
      end else if (bus.to_ref) begin
        data_lock_q <= 1'b0;
      end else begin
        data_lock_q <= cdr_lock_q;
      end
    end
  end

  assign bus.cdr_lock = cdr_lock_q;
  assign bus.data_lock = data_lock_q;
endmodule

// ===== trp_cdr_if.sv
interface trp_cdr_if;
  import trp_pkg::*;
  // Per-channel CDR controls and status
  logic analog_rst;
  logic to_ref;
  logic to_data;
  logic pll_ok;
  logic cdr_lock;
  logic data_lock;
  modport ctl (output analog_rst, output to_ref, output to_data,
    output pll_ok, input cdr_lock, input data_lock);
  modport cdr (input analog_rst, input to_ref, input to_data,
    input pll_ok, output cdr_lock, output data_lock);
endinterface

// ===== trp_ctl_model.sv
module trp_ctl_model (
  input wire logic aclk,
  output logic [7:0] awa,
  output logic awv,
  input wire logic awr,
  output logic [31:0] wda,
  output logic [3:0] wst,
  output logic wva,
  input wire logic wre,
  input wire logic [1:0] brs,
  input wire logic bva,
  output logic bre,
  output logic [7:0] ara,
  output logic arv,
  input wire logic arr,
  input wire logic [31:0] rda,
  input wire logic [1:0] rrs,
  input wire logic rva,
  output logic rre
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------
  // Register master of the reset controller
  // ----------------------------------------------
  // Quiet bus at time zero
  initial {awa, awv, wda, wst, wva, bre, ara, arv, rre} = '0;
  // Released payload is inverted so stale values never pass
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    bit aw_ok;
    bit w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    awa <= a;
    awv <= 1'b1;
    wda <= d;
    wst <= 4'hF;
    wva <= 1'b1;
    bre <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && awr === 1'b1) begin
        aw_ok = 1'b1;
        awv <= 1'b0;
        awa <= ~a;
      end
      if (!w_ok && wre === 1'b1) begin
        w_ok = 1'b1;
        wva <= 1'b0;
        wda <= ~d;
      end
    end
    while (bva !== 1'b1) @(posedge aclk);
    r = brs;
    bre <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    do @(posedge aclk); while (arr !== 1'b1);
    arv <= 1'b0;
    ara <= ~a;
    while (rva !== 1'b1) @(posedge aclk);
    d = rda;
    r = rrs;
    rre <= 1'b0;
  endtask
endmodule

// ===== trp_pkg.sv
package trp_pkg;
  // ----------------------------------------------------------------
  // Block geometry
  // ----------------------------------------------------------------
  localparam int NUM_CH = 4;
  localparam int NUM_PLL = 2;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CH_RESET = 8'h00;
  localparam logic [7:0] OFF_PWR = 8'h04;
  localparam logic [7:0] OFF_CDR_MODE = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  localparam logic [7:0] OFF_CH_STATE = 8'h10;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CHR_TX_LSB = 0;
  localparam int CHR_RXL_LSB = 4;
  localparam int CHR_RXR_LSB = 8;
  localparam int PWR_PLL_LSB = 0;
  localparam int PWR_BLK_BIT = 2;
  localparam int CDR_REF_LSB = 0;
  localparam int CDR_DATA_LSB = 4;
  localparam int ST_TXLOCK_LSB = 0;
  localparam int ST_CDRLOCK_LSB = 2;
  localparam int ST_DATALOCK_LSB = 6;
  localparam int ST_BUSY_BIT = 10;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [11:0] RST_CH_RESET = 12'h0FFF;
  localparam logic [2:0] RST_PWR = 3'h3;
  localparam logic [7:0] RST_CDR_MODE = 8'h00;

  // ----------------------------------------------------------------
  // Timing: PLL lock time and offset cancellation time
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int T_PLL_LOCK_NS = 1000;
  localparam int PLL_LOCK_CYC = (T_PLL_LOCK_NS * CLK_MHZ) / 1000;
  localparam int T_OC_NS = 2000;
  localparam int OC_CYC = (T_OC_NS * CLK_MHZ) / 1000;
  localparam int T_CDR_LOCK_NS = 500;
  localparam int CDR_LOCK_CYC = (T_CDR_LOCK_NS * CLK_MHZ) / 1000;
  localparam int CNT_W = 12;

  // ----------------------------------------------------------------
  // AXI responses
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Busy sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    BUSY_FIRST = 3'b001,
    BUSY_RUN = 3'b010,
    BUSY_DONE = 3'b100
  } trp_busy_e;
endpackage

// ===== trp_top.sv
// Contract
// - Reset and power-down inputs act without waiting on any clock; this model applies them only on aclk edges.
// - Transmit logic reset clears all transmit coding logic.
// - Receive logic reset clears receive coding logic and verifiers.
// - Receive recovery reset clears that channel's CDR.
// - Each of two multiplier PLLs has its own power-down stopping clocks.
// - Block power-down stops every channel and both PLLs.
// - Block power-down is independent and shared by all channels.
// - No power-down affects the reference clock input buffers.
// - Transmit PLL lock is high only while that PLL is locked.
// - CDR lock is high while the CDR locks to reference.
// - Data lock high when tracking data, low when tracking reference.
// - Busy low first cycle, high from second during offset cancel.
// - Busy falling marks offset cancellation complete.
// - Transmit reset clears FIFO, serializers, encoder, not output buffer.
// - Reference-tracking, data-tracking or automatic CDR mode by two bits.
//
// Register access over AXI4-Lite and the register offsets were left to the implementer.
module trp_top (
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Resulting per-channel and per-PLL state
  output logic [trp_pkg::NUM_CH-1:0] tx_active,
  output logic [trp_pkg::NUM_CH-1:0] rx_active,
  output logic [trp_pkg::NUM_PLL-1:0] clock_multiplier_running,
  output logic refclk_buf_on
);
  import trp_pkg::*;

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  logic [NUM_CH-1:0] tx_rst_q;
  logic [NUM_CH-1:0] rxl_rst_q;
  logic [NUM_CH-1:0] rxr_rst_q;
  logic [NUM_PLL-1:0] pll_pd_q;
  logic blk_pd_q;
  logic [NUM_CH-1:0] ref_trk_q;
  logic [NUM_CH-1:0] data_trk_q;

  // ----------------------------------------------------------------
  // Status state
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] pll_cnt_q [NUM_PLL];
  logic [NUM_PLL-1:0] pll_lock_q;
  logic [NUM_CH-1:0] cdr_lock;
  logic [NUM_CH-1:0] data_lock;
  logic [NUM_CH-1:0] tx_act_q;
  logic [NUM_CH-1:0] rx_act_q;
  logic [NUM_PLL-1:0] pll_run_q;
  trp_busy_e busy_st_q;
  logic [CNT_W-1:0] oc_cnt_q;
  logic busy_q;

  // ----------------------------------------------------------------
  // Bus slave state
  // ----------------------------------------------------------------
  logic aw_hold_q;
  logic [7:0] aw_addr_q;
  logic w_hold_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic do_write;

  // Byte-lane merge used by every writable register
  function automatic logic [31:0] merge(input logic [31:0] old_v,
    input logic [31:0] new_v, input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Address decode shared by read and write paths
  function automatic logic mapped(input logic [7:0] a, input logic wr);
    case (a)
      OFF_CH_RESET, OFF_PWR, OFF_CDR_MODE: mapped = 1'b1;
      OFF_STATUS, OFF_CH_STATE: mapped = !wr;
      default: mapped = 1'b0;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Write channel capture
  // ----------------------------------------------------------------
  // Address and data may arrive in either order; each is held
  // until both are present and the previous response is taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      aw_addr_q <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end else if (do_write) begin
      aw_hold_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold_q <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_hold_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end else if (do_write) begin
      w_hold_q <= 1'b0;
    end
  end

  assign do_write = aw_hold_q && w_hold_q && !bvalid_q;

  // Ready flags are registers so every output leaves a flip-flop
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_hold_q && !(s_axi_awvalid && s_axi_awready)
        && !bvalid_q;
      s_axi_wready <= !w_hold_q && !(s_axi_wvalid && s_axi_wready)
        && !bvalid_q;
    end
  end

  // Write response, one per completed write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q <= mapped(aw_addr_q, 1'b1) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Reset and power-down control registers
  // ----------------------------------------------------------------
  // The analog cores take these levels asynchronously; the
  // register only decides when software changes them.
  always_ff @(posedge aclk) begin
    logic [31:0] v;
    v = '0;
    if (!aresetn) begin
      tx_rst_q <= RST_CH_RESET[CHR_TX_LSB +: NUM_CH];
      rxl_rst_q <= RST_CH_RESET[CHR_RXL_LSB +: NUM_CH];
      rxr_rst_q <= RST_CH_RESET[CHR_RXR_LSB +: NUM_CH];
    end else if (do_write && aw_addr_q == OFF_CH_RESET) begin
      v = merge({20'h0_0000, rxr_rst_q, rxl_rst_q, tx_rst_q}, w_data_q,
        w_strb_q);
      tx_rst_q <= v[CHR_TX_LSB +: NUM_CH];
      rxl_rst_q <= v[CHR_RXL_LSB +: NUM_CH];
      rxr_rst_q <= v[CHR_RXR_LSB +: NUM_CH];
    end
  end

  always_ff @(posedge aclk) begin
    logic [31:0] v;
    v = '0;
    if (!aresetn) begin
      pll_pd_q <= RST_PWR[PWR_PLL_LSB +: NUM_PLL];
      blk_pd_q <= RST_PWR[PWR_BLK_BIT];
    end else if (do_write && aw_addr_q == OFF_PWR) begin
      v = merge({29'h0, blk_pd_q, pll_pd_q}, w_data_q, w_strb_q);
      pll_pd_q <= v[PWR_PLL_LSB +: NUM_PLL];
      blk_pd_q <= v[PWR_BLK_BIT];
    end
  end

  always_ff @(posedge aclk) begin
    logic [31:0] v;
    v = '0;
    if (!aresetn) begin
      ref_trk_q <= RST_CDR_MODE[CDR_REF_LSB +: NUM_CH];
      data_trk_q <= RST_CDR_MODE[CDR_DATA_LSB +: NUM_CH];
    end else if (do_write && aw_addr_q == OFF_CDR_MODE) begin
      v = merge({24'h00_0000, data_trk_q, ref_trk_q}, w_data_q, w_strb_q);
      ref_trk_q <= v[CDR_REF_LSB +: NUM_CH];
      data_trk_q <= v[CDR_DATA_LSB +: NUM_CH];
    end
  end

  // ----------------------------------------------------------------
  // Multiplier PLLs: lock after a fixed time once powered
  // ----------------------------------------------------------------
  generate
    for (genvar p = 0; p < NUM_PLL; p++) begin : g_pll
      always_ff @(posedge aclk) begin
        if (!aresetn || pll_pd_q[p] || blk_pd_q) begin
          pll_cnt_q[p] <= '0;
          pll_lock_q[p] <= 1'b0;
          pll_run_q[p] <= 1'b0;
        end else begin
          if (pll_cnt_q[p] != CNT_W'(PLL_LOCK_CYC)) begin
            pll_cnt_q[p] <= pll_cnt_q[p] + CNT_W'(1);
          end
          pll_lock_q[p] <= (pll_cnt_q[p] == CNT_W'(PLL_LOCK_CYC));
          pll_run_q[p] <= 1'b1;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Channels: PLL 0 feeds even channels, PLL 1 odd ones
  // ----------------------------------------------------------------
  generate
    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
      trp_cdr_if cif ();
      assign cif.analog_rst = rxr_rst_q[c] || blk_pd_q;
      assign cif.to_ref = ref_trk_q[c];
      assign cif.to_data = data_trk_q[c];
      assign cif.pll_ok = !blk_pd_q;
      assign cdr_lock[c] = cif.cdr_lock;
      assign data_lock[c] = cif.data_lock;

      trp_cdr u_cdr (
        .aclk(aclk),
        .aresetn(aresetn),
        .bus(cif.cdr)
      );

      // Transmit coding path runs only out of reset with a clock;
      // the output buffer is not part of this reset.
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          tx_act_q[c] <= 1'b0;
          rx_act_q[c] <= 1'b0;
        end else begin
          tx_act_q[c] <= !tx_rst_q[c] && !blk_pd_q
            && pll_lock_q[c % NUM_PLL];
          rx_act_q[c] <= !rxl_rst_q[c] && !blk_pd_q
            && cdr_lock[c];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Offset cancellation busy flag
  // ----------------------------------------------------------------
  // One quiet cycle after reset, then busy for the cancel time.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_st_q <= BUSY_FIRST;
      oc_cnt_q <= '0;
      busy_q <= 1'b0;
    end else begin
      case (busy_st_q)
        BUSY_FIRST: begin
          busy_st_q <= BUSY_RUN;
          busy_q <= 1'b1;
        end
        BUSY_RUN: begin
          oc_cnt_q <= oc_cnt_q + CNT_W'(1);
          if (oc_cnt_q == CNT_W'(OC_CYC - 1)) begin
            busy_st_q <= BUSY_DONE;
            busy_q <= 1'b0;
          end
        end
        BUSY_DONE: begin
          busy_q <= 1'b0;
        end
        default: begin
          busy_st_q <= BUSY_FIRST;
          busy_q <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
      s_axi_arready <= 1'b0;
    end else if (rvalid_q) begin
      s_axi_arready <= 1'b0;
      if (s_axi_rready) begin
        rvalid_q <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      rvalid_q <= 1'b1;
      rresp_q <= mapped(s_axi_araddr, 1'b0) ? RESP_OKAY : RESP_SLVERR;
      case (s_axi_araddr)
        OFF_CH_RESET: rdata_q <= {20'h0_0000, rxr_rst_q, rxl_rst_q,
          tx_rst_q};
        OFF_PWR: rdata_q <= {29'h0, blk_pd_q, pll_pd_q};
        OFF_CDR_MODE: rdata_q <= {24'h00_0000, data_trk_q, ref_trk_q};
        OFF_STATUS: rdata_q <= {21'h00_0000, busy_q, data_lock, cdr_lock,
          pll_lock_q};
        OFF_CH_STATE: rdata_q <= {24'h00_0000, rx_act_q, tx_act_q};
        default: rdata_q <= '0;
      endcase
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  // Reference buffers never follow any power-down
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      refclk_buf_on <= 1'b0;
    end else begin
      refclk_buf_on <= 1'b1;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign tx_active = tx_act_q;
  assign rx_active = rx_act_q;
  assign clock_multiplier_running = pll_run_q;
endmodule

// ===== trp_top_checker.sv
module trp_top_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic [trp_pkg::NUM_CH-1:0] tx_active,
  input wire logic [trp_pkg::NUM_CH-1:0] rx_active,
  input wire logic [trp_pkg::NUM_PLL-1:0] clock_multiplier_running,
  input wire logic refclk_buf_on
);
  timeunit 1ns;
  timeprecision 1ps;
  import trp_pkg::*;
  // ----------------------------------------------
  // Address of the read in flight, for data checks
  // ----------------------------------------------
  logic [7:0] ar_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ar_q <= 8'h00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      ar_q <= s_axi_araddr;
    end
  end
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Buffer stays on whatever else is powered down
  refclk_kept_a: assert property (
    $past(aresetn, 2) |-> refclk_buf_on) else $error("refclk buffer off");
  // A PLL just powered needs far more than eight cycles to lock
  pll_wait_a: assert property (
    $rose(clock_multiplier_running[0])
    |-> (!tx_active[0] && !tx_active[2]) [*8]) else $error("early lock");
  pll_stop_a: assert property (
    $fell(clock_multiplier_running[1])
    |-> ##[0:2] !(tx_active[1] || tx_active[3]))
    else $error("tx running on stopped pll");
  // Bus answers with the figures of the hand-over
  wr_answer_a: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid && !s_axi_awready) else $error("no write answer");
  rd_answer_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("no read answer");
  b_release_a: assert property (
    s_axi_bvalid && s_axi_bready
    |=> !s_axi_bvalid ##[0:1] (s_axi_awready && s_axi_wready))
    else $error("write channel not released");
  ro_refuse_a: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready &&
    (s_axi_awaddr == OFF_STATUS || s_axi_awaddr == OFF_CH_STATE)
    |-> ##2 s_axi_bresp == RESP_SLVERR) else $error("read-only write taken");
  // Only compared when the outputs hold still across the read
  state_mirror_a: assert property (
    $rose(s_axi_rvalid) && ar_q == OFF_CH_STATE && $stable(tx_active) &&
    $stable(rx_active) |-> s_axi_rdata[7:0] == {rx_active, tx_active})
    else $error("channel state mismatch");
  status_pad_a: assert property (
    s_axi_rvalid && ar_q == OFF_STATUS |-> s_axi_rdata[31:11] == '0)
    else $error("status pad bits set");
  wr_c: cover property (s_axi_bvalid && s_axi_bready);
  tx_c: cover property ($rose(tx_active[0]));
  rx_c: cover property ($rose(rx_active[3]));
endmodule
